/* File: rtl/lfs_defs.svh */
// Purpose: Constants of the laser fault supervisor
// Assumes: 10 MHz system clock
// Notes: Offsets are byte addresses on the register port
`ifndef LFS_DEFS_SVH
`define LFS_DEFS_SVH

// Clock and timing
`define LFS_CLK_HZ 10000000
`define LFS_CLK_NS 100
`define LFS_MS_CYC(ms) ((ms) * (`LFS_CLK_HZ / 1000))
`define LFS_LASE_DELAY_S 5
`define LFS_LASE_DELAY_CYC (`LFS_LASE_DELAY_S * `LFS_CLK_HZ)
`define LFS_PULSE_CAP_NS 12000
`define LFS_PULSE_CAP_CYC (`LFS_PULSE_CAP_NS / `LFS_CLK_NS)
`define LFS_BLINK_ON_MS 250
`define LFS_BLINK_OFF_MS 250
`define LFS_BLINK_GAP_MS 1500
`define LFS_FLASH_MS 250

// Fault codes shown on the ready indicator
`define LFS_CODE_NONE 2'h0
`define LFS_CODE_UNDER 2'h1
`define LFS_CODE_OVER 2'h2
`define LFS_CODE_RF 2'h3

// Register offsets
`define LFS_REG_STATUS 4'h0
`define LFS_REG_CLEAR 4'h4
`define LFS_REG_ENABLE 4'h8
`define LFS_REG_STATE 4'hC

// Event bit positions (status, clear, enable)
`define LFS_EV_UNDER 0
`define LFS_EV_OVER 1
`define LFS_EV_RF 2
`define LFS_EV_ILK 3
`define LFS_EV_TEMP 4
`define LFS_EV_MISMATCH 5
`define LFS_EV_W 6

// Reset values
`define LFS_ENABLE_RST 6'h00
`define LFS_STATUS_RST 6'h00

`endif

/* File: rtl/lfs_pkg.sv */
// Purpose: Types of the laser fault supervisor
// Assumes: Constants come from lfs_defs.svh
// Notes: None
package lfs_pkg;
  typedef logic [1:0] lfs_code_t;
  typedef enum logic [1:0] {BLK_IDLE, BLK_ON, BLK_OFF, BLK_GAP} lfs_blink_st_t;
endpackage

/* File: rtl/lfs_blink.sv */
// Purpose: Blink code generator for the ready indicator
// Assumes: Code stays stable while a sequence runs
// Notes: Code zero leaves the output dark
`timescale 1ns/1ns
`include "lfs_defs.svh"
module lfs_blink import lfs_pkg::*; #(
  parameter int unsigned ON_CYC = `LFS_MS_CYC(`LFS_BLINK_ON_MS),
  parameter int unsigned OFF_CYC = `LFS_MS_CYC(`LFS_BLINK_OFF_MS),
  parameter int unsigned GAP_CYC = `LFS_MS_CYC(`LFS_BLINK_GAP_MS),
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Code and indicator
  input wire lfs_code_t code,
  output logic led
);

  lfs_blink_st_t state_r;
  logic [CW-1:0] cnt_r;
  logic [1:0] left_r;
  logic led_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: N on/off blinks, then a long gap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= BLK_IDLE;
      cnt_r <= '0;
      left_r <= 2'h0;
    end else begin
      unique case (state_r)
        BLK_IDLE: begin
          if (code != `LFS_CODE_NONE) begin
            state_r <= BLK_ON;
            left_r <= code;
            cnt_r <= CW'(ON_CYC - 1);
          end
        end
        BLK_ON: begin
          if (cnt_r == '0) begin
            state_r <= BLK_OFF;
            left_r <= left_r - 2'h1;
            cnt_r <= CW'(OFF_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        BLK_OFF: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (left_r == 2'h0) begin
            state_r <= BLK_GAP;
            cnt_r <= CW'(GAP_CYC - 1);
          end else begin
            state_r <= BLK_ON;
            cnt_r <= CW'(ON_CYC - 1);
          end
        end
        BLK_GAP: begin
          if (cnt_r == '0) begin
            state_r <= BLK_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered indicator drive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_r <= 1'b0;
    end else begin
      led_r <= (state_r == BLK_ON);
    end
  end

  assign led = led_r;

endmodule // lfs_blink

/* File: rtl/lfs_supervisor.sv */
// Purpose: Fault supervisor of an RF-excited CO2 laser controller
// Assumes: Sensed fault levels are synchronous; sys_rst is the power cycle
// Notes: Contact outputs are 1 for closed
`timescale 1ns/1ns
`include "lfs_defs.svh"
module lfs_supervisor import lfs_pkg::*; #(
  parameter int unsigned DELAY_CYC = `LFS_LASE_DELAY_CYC,
  parameter int DW = 26,
  parameter int unsigned CAP_CYC = `LFS_PULSE_CAP_CYC,
  parameter int PW = 8,
  parameter int unsigned FLASH_CYC = `LFS_MS_CYC(`LFS_FLASH_MS),
  parameter int unsigned BLINK_ON_CYC = `LFS_MS_CYC(`LFS_BLINK_ON_MS),
  parameter int unsigned BLINK_OFF_CYC = `LFS_MS_CYC(`LFS_BLINK_OFF_MS),
  parameter int unsigned BLINK_GAP_CYC = `LFS_MS_CYC(`LFS_BLINK_GAP_MS)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sensed conditions
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic rf_switch_fault,
  input wire logic over_temp,
  input wire logic impedance_mismatch_fault,
  // User inputs
  input wire logic interlock_closed,
  input wire logic shutter_req,
  input wire logic keyswitch_fitted,
  input wire logic keyswitch_on,
  input wire logic start_req,
  input wire logic pwm_cmd,
  // Drive
  output logic rf_enable,
  output logic pwm_out,
  // Indicators
  output logic led_ready,
  output logic shutter_indicator,
  output logic led_lase,
  output logic led_ilk_red,
  output logic led_temp_red,
  // Status contacts
  output logic st_interlock_open,
  output logic st_over_temp,
  output logic st_laser_ready,
  output logic st_shutter_open,
  output logic st_laser_active,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  logic cap_done_r;
  logic keysw_fit_r;
  logic keysw_d_r;
  logic armed_r;
  logic under_r;
  logic over_r;
  logic rf_r;
  logic temp_r;
  logic ilk_d_r;
  lfs_code_t fault_code;
  logic blink_led;
  logic ready_nxt;
  logic ready_r;
  logic [DW-1:0] delay_cnt_r;
  logic delay_done_r;
  logic pwm_d_r;
  logic mm_r;
  logic [PW-1:0] pw_cnt_r;
  logic cap_hit;
  logic pwm_out_r;
  logic [31:0] flash_cnt_r;
  logic flash_ph_r;
  logic led_ready_r;
  logic shut_ind_r;
  logic shut_open_r;
  logic ilk_red_r;
  logic [`LFS_EV_W-1:0] ev;
  logic [`LFS_EV_W-1:0] sts_r;
  logic [`LFS_EV_W-1:0] en_r;
  logic [31:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Keyswitch strap, caught once after reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_done_r <= 1'b0;
      keysw_fit_r <= 1'b0;
    end else if (!cap_done_r) begin
      cap_done_r <= 1'b1;
      keysw_fit_r <= keyswitch_fitted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arming: keyswitch units need off-to-on or a start pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      keysw_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      keysw_d_r <= keyswitch_on;
      if (!cap_done_r) begin
        armed_r <= 1'b0;
      end else if (!keysw_fit_r) begin
        armed_r <= 1'b1;
      end else if (!interlock_closed) begin
        armed_r <= 1'b0;
      end else if (keyswitch_on && (!keysw_d_r || start_req)) begin
        armed_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched faults, cleared only by reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      under_r <= 1'b0;
      over_r <= 1'b0;
      rf_r <= 1'b0;
      temp_r <= 1'b0;
    end else begin
      under_r <= under_r | supply_low;
      over_r <= over_r | supply_high;
      rf_r <= rf_r | rf_switch_fault;
      temp_r <= temp_r | over_temp;
    end
  end

  // Priority encoder of the blink code
  always_comb begin
    fault_code = `LFS_CODE_NONE;
    if (under_r) begin
      fault_code = `LFS_CODE_UNDER;
    end else if (over_r) begin
      fault_code = `LFS_CODE_OVER;
    end else if (rf_r) begin
      fault_code = `LFS_CODE_RF;
    end
  end

  lfs_blink #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC),
    .GAP_CYC(BLINK_GAP_CYC),
    .CW(32)
  ) u_blink (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(fault_code),
    .led(blink_led)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ready and lasing delay
  assign ready_nxt = cap_done_r & armed_r & interlock_closed & ~under_r & ~over_r
                     & ~rf_r & ~temp_r & ~over_temp;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
      delay_cnt_r <= '0;
      delay_done_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
      if (!ready_nxt) begin
        delay_cnt_r <= '0;
        delay_done_r <= 1'b0;
      end else if (ready_r && !delay_done_r) begin
        if (delay_cnt_r == DW'(DELAY_CYC - 1)) begin
          delay_done_r <= 1'b1;
        end else begin
          delay_cnt_r <= delay_cnt_r + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Impedance mismatch, evaluated at the PWM leading edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_d_r <= 1'b0;
      mm_r <= 1'b0;
    end else begin
      pwm_d_r <= pwm_cmd;
      if (pwm_cmd && !pwm_d_r && impedance_mismatch_fault) begin
        mm_r <= 1'b1;
      end else if (!impedance_mismatch_fault) begin
        mm_r <= 1'b0;
      end
    end
  end

  // Pulse width counter, saturating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pw_cnt_r <= '0;
    end else if (!pwm_cmd) begin
      pw_cnt_r <= '0;
    end else if (pw_cnt_r != PW'(CAP_CYC)) begin
      pw_cnt_r <= pw_cnt_r + 1'b1;
    end
  end

  assign cap_hit = mm_r & (pw_cnt_r == PW'(CAP_CYC));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_out_r <= 1'b0;
    end else begin
      pwm_out_r <= ready_r & delay_done_r & shutter_req & pwm_cmd & ~cap_hit;
    end
  end

  // RF power only when ready, lasing delay done and shutter requested
  assign rf_enable = ready_r & delay_done_r & shutter_req;
  assign pwm_out = pwm_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Indicators
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_cnt_r <= '0;
      flash_ph_r <= 1'b0;
    end else if (flash_cnt_r == 32'(FLASH_CYC - 1)) begin
      flash_cnt_r <= '0;
      flash_ph_r <= ~flash_ph_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_ready_r <= 1'b0;
      shut_ind_r <= 1'b0;
      shut_open_r <= 1'b0;
      ilk_red_r <= 1'b0;
    end else begin
      led_ready_r <= (fault_code != `LFS_CODE_NONE) ? blink_led : ready_nxt;
      shut_ind_r <= shutter_req & (~mm_r | flash_ph_r);
      shut_open_r <= shutter_req;
      ilk_red_r <= ~interlock_closed;
    end
  end

  assign led_ready = led_ready_r;
  assign shutter_indicator = shut_ind_r;
  assign led_lase = pwm_out_r;
  assign led_ilk_red = ilk_red_r;
  assign led_temp_red = temp_r;
  assign st_interlock_open = ilk_red_r;
  assign st_over_temp = temp_r;
  assign st_laser_ready = ready_r;
  assign st_shutter_open = shut_open_r;
  assign st_laser_active = pwm_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Events, sticky status, interrupt
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ilk_d_r <= 1'b0;
    end else begin
      ilk_d_r <= interlock_closed;
    end
  end

  assign ev[`LFS_EV_UNDER] = supply_low & ~under_r;
  assign ev[`LFS_EV_OVER] = supply_high & ~over_r;
  assign ev[`LFS_EV_RF] = rf_switch_fault & ~rf_r;
  assign ev[`LFS_EV_ILK] = ilk_d_r & ~interlock_closed;
  assign ev[`LFS_EV_TEMP] = over_temp & ~temp_r;
  assign ev[`LFS_EV_MISMATCH] = pwm_cmd & ~pwm_d_r & impedance_mismatch_fault;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sts_r <= `LFS_STATUS_RST;
    end else begin
      if (reg_wr && reg_addr == `LFS_REG_CLEAR) begin
        sts_r <= (sts_r & ~reg_wdata[`LFS_EV_W-1:0]) | ev;
      end else begin
        sts_r <= sts_r | ev;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= `LFS_ENABLE_RST;
    end else if (reg_wr && reg_addr == `LFS_REG_ENABLE) begin
      en_r <= reg_wdata[`LFS_EV_W-1:0];
    end
  end

  assign irq = |(sts_r & en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `LFS_REG_STATUS: rdata_r <= {26'h0, sts_r};
        `LFS_REG_ENABLE: rdata_r <= {26'h0, en_r};
        `LFS_REG_STATE: rdata_r <= {22'h0, fault_code, mm_r, delay_done_r, ready_r,
                                    armed_r, temp_r, rf_r, over_r, under_r};
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [PW:0] mm_run_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mm_run_r <= '0;
    end else if (pwm_out_r && mm_r) begin
      mm_run_r <= mm_run_r + 1'b1;
    end else begin
      mm_run_r <= '0;
    end
  end

  a_fire_gate: assert property (pwm_out_r |->
    $past(ready_r && delay_done_r && shutter_req && pwm_cmd))
    else $error("Fired without all enables");
  a_pulse_cap: assert property (mm_run_r <= (PW+1)'(CAP_CYC))
    else $error("Mismatch pulse too long");
  a_ready_drop: assert property ((temp_r || !interlock_closed) |=> !ready_r)
    else $error("Ready held during fault");
  a_delay_restart: assert property ($rose(ready_r) |->
    !delay_done_r ##1 !delay_done_r) else $error("Delay not restarted");
  a_temp_latch: assert property (temp_r |=> temp_r && led_temp_red)
    else $error("Temperature latch released");
  a_code_under: assert property (under_r |-> fault_code == `LFS_CODE_UNDER)
    else $error("Wrong under code");
  a_code_over: assert property ((over_r && !under_r) |->
    fault_code == `LFS_CODE_OVER) else $error("Wrong over code");
  a_code_rf: assert property ((rf_r && !under_r && !over_r) |->
    fault_code == `LFS_CODE_RF) else $error("Wrong RF code");
  a_ilk_auto: assert property ((cap_done_r && !keysw_fit_r && !temp_r && !over_temp
    && fault_code == `LFS_CODE_NONE && interlock_closed) ##1 (!temp_r && !over_temp
    && fault_code == `LFS_CODE_NONE && interlock_closed) |=> ready_r)
    else $error("Interlock restore did not ready");
  a_mm_clear: assert property (!impedance_mismatch_fault |=> !mm_r)
    else $error("Mismatch cap held");
  a_sticky_set: assert property (ev[`LFS_EV_TEMP] |=> sts_r[`LFS_EV_TEMP])
    else $error("Event lost");

  c_delay_done: cover property ($rose(delay_done_r));
  c_cap_hit: cover property (cap_hit && pwm_cmd);
  c_rf_blink: cover property (fault_code == `LFS_CODE_RF && led_ready_r);
  c_ilk_back: cover property ($rose(interlock_closed) ##[1:3] ready_r);

endmodule // lfs_supervisor

/* File: dv/lfs_oem_model.sv */
// Purpose: System controller model driving power, start request and PWM command
// Assumes: Shares the 10 MHz clock of the supervisor
// Notes: Power-off span is scaled from seconds down to cycles
`timescale 1ns/1ns
module lfs_oem_model #(
  parameter int OFF_CYC = 30
) (
  // Clock
  input wire logic clk,
  // Drive to the supervisor
  output logic sys_rst,
  output logic start_req,
  output logic pwm_cmd
);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    start_req = 1'b0;
    pwm_cmd = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Power off, hold off, reapply
  task automatic power_cycle();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (OFF_CYC) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // One-cycle remote start request
  task automatic start_pulse();
    @(posedge clk);
    start_req <= 1'b1;
    @(posedge clk);
    start_req <= 1'b0;
  endtask
  // PWM command pulse of len cycles
  task automatic pulse(input int len);
    @(posedge clk);
    pwm_cmd <= 1'b1;
    repeat (len) @(posedge clk);
    pwm_cmd <= 1'b0;
  endtask
endmodule // lfs_oem_model

/* File: dv/tb.sv */
// Purpose: Self-checking bench of the laser fault supervisor
// Assumes: Shortened delay and blink counts
// Notes: Register reads are scored from a queue of notes
`timescale 1ns/1ns
`include "lfs_defs.svh"
module tb import lfs_pkg::*;;
  localparam int DLY = 50;
  typedef struct {logic [31:0] exp; logic [31:0] msk;} lfs_note_t;
  logic clk, sys_rst, start_req, pwm_cmd, over_temp, mm, ilk, shut, key_fit, key_on;
  logic [2:0] flt;
  logic rf_enable, pwm_out, led_ready, shutter_indicator, led_lase, led_ilk_red, led_temp_red;
  logic st_interlock_open, st_over_temp, st_laser_ready, st_shutter_open, st_laser_active;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, irq;
  logic rd_q = 1'b0, sh_q = 1'b0, rdy_q = 1'b0;
  int num_errors = 0, cmp_count = 0, seed = 32'h8fe6;
  int hi_cnt = 0, tog = 0, rise = 0, c0, len;
  lfs_note_t notes[$];
  lfs_note_t n;
  ////////////////////////////////////////////////////////////////////////////
  lfs_oem_model ctl (.clk(clk), .sys_rst(sys_rst), .start_req(start_req), .pwm_cmd(pwm_cmd));
  lfs_supervisor #(.DELAY_CYC(DLY), .FLASH_CYC(4), .BLINK_ON_CYC(3), .BLINK_OFF_CYC(3),
    .BLINK_GAP_CYC(10)) uut (.clk(clk), .sys_rst(sys_rst), .supply_low(flt[0]),
    .supply_high(flt[1]), .rf_switch_fault(flt[2]), .over_temp(over_temp),
    .impedance_mismatch_fault(mm), .interlock_closed(ilk), .shutter_req(shut),
    .keyswitch_fitted(key_fit), .keyswitch_on(key_on), .start_req(start_req),
    .pwm_cmd(pwm_cmd), .rf_enable(rf_enable), .pwm_out(pwm_out), .led_ready(led_ready),
    .shutter_indicator(shutter_indicator), .led_lase(led_lase), .led_ilk_red(led_ilk_red),
    .led_temp_red(led_temp_red), .st_interlock_open(st_interlock_open),
    .st_over_temp(st_over_temp), .st_laser_ready(st_laser_ready),
    .st_shutter_open(st_shutter_open), .st_laser_active(st_laser_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{e, m});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Scores each read data word against the oldest note
  always @(posedge clk) begin
    if (rd_q) begin
      n = notes.pop_front();
      chk(reg_rdata & n.msk, n.exp);
    end
    rd_q <= reg_rd;
    if (pwm_out) hi_cnt <= hi_cnt + 1;
    if (shutter_indicator !== sh_q) tog <= tog + 1;
    if (led_ready && !rdy_q) rise <= rise + 1;
    sh_q <= shutter_indicator;
    rdy_q <= led_ready;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {over_temp, mm, key_fit, reg_wr, reg_rd} = '0;
    key_on = 1'($random(seed));
    {ilk, shut} = 2'b11;
    flt = 3'b000;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    tick(2);
    chk(led_ready, 1'b0);
    tick(6);
    chk(st_laser_ready, 1'b1);
    chk(rf_enable, 1'b0);
    reg_read(`LFS_REG_ENABLE, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_read(`LFS_REG_CLEAR, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_read(4'h2, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_write(`LFS_REG_STATUS, 32'($random(seed)) | 32'h0000_003F);
    reg_read(`LFS_REG_STATUS, 32'h0000_0000, 32'h0000_003F);
    tick(DLY - 20);
    chk(rf_enable, 1'b0);
    tick(20);
    chk(rf_enable, 1'b1);
    len = 10 + ($unsigned($random(seed)) % 50);
    c0 = hi_cnt;
    fork
      ctl.pulse(len);
      begin
        tick(4);
        chk({led_lase, st_laser_active}, 2'b11);
      end
    join
    tick(4);
    chk(hi_cnt - c0, len);
    shut <= 1'b0;
    c0 = hi_cnt;
    ctl.pulse(20);
    tick(4);
    chk(32'(hi_cnt - c0), 32'h0000_0000);
    chk({rf_enable, st_shutter_open}, 2'b00);
    shut <= 1'b1;
    mm <= 1'b1;
    {c0, len} = {hi_cnt, tog};
    ctl.pulse(200);
    tick(4);
    chk(hi_cnt - c0, 120);
    chk(tog - len > 8, 1);
    chk(st_shutter_open, 1'b1);
    reg_read(`LFS_REG_STATUS, 32'h0000_0020, 32'h0000_0020);
    mm <= 1'b0;
    tick(3);
    c0 = hi_cnt;
    ctl.pulse(200);
    tick(4);
    chk(hi_cnt - c0, 200);
    reg_write(`LFS_REG_CLEAR, 32'h0000_003F);
    reg_write(`LFS_REG_ENABLE, 32'h0000_0008);
    ilk <= 1'b0;
    tick(3);
    chk({led_ilk_red, st_interlock_open, irq}, 3'b111);
    chk({st_laser_ready, rf_enable}, 2'b00);
    ilk <= 1'b1;
    tick(6);
    chk({led_ilk_red, st_laser_ready, rf_enable}, 3'b010);
    reg_read(`LFS_REG_STATUS, 32'h0000_0008, 32'h0000_003F);
    reg_read(`LFS_REG_ENABLE, 32'h0000_0008, 32'hFFFF_FFFF);
    reg_write(`LFS_REG_CLEAR, 32'h0000_0008);
    tick(2);
    chk(irq, 1'b0);
    tick(DLY);
    chk(rf_enable, 1'b1);
    over_temp <= 1'b1;
    tick(3);
    over_temp <= 1'b0;
    tick(10);
    chk({led_temp_red, st_over_temp, st_laser_ready, rf_enable}, 4'b1100);
    ctl.power_cycle();
    tick(6);
    chk({led_temp_red, st_laser_ready}, 2'b01);
    for (int code = 1; code <= 3; code++) begin
      ctl.power_cycle();
      tick(6);
      flt <= 3'b001 << (code - 1);
      tick(2);
      flt <= 3'b000;
      tick(40);
      c0 = rise;
      tick(code * 6 + 11);
      chk(rise - c0, code);
      chk(st_laser_ready, 1'b0);
      reg_read(`LFS_REG_STATE, code << 8, 32'h0000_0300);
    end
    key_on <= 1'b0;
    key_fit <= 1'b1;
    ctl.power_cycle();
    tick(10);
    chk(st_laser_ready, 1'b0);
    key_on <= 1'b1;
    tick(5);
    chk(st_laser_ready, 1'b1);
    ilk <= 1'b0;
    tick(3);
    ilk <= 1'b1;
    tick(6);
    chk(st_laser_ready, 1'b0);
    ctl.start_pulse();
    tick(5);
    chk(st_laser_ready, 1'b1);
    ctl.power_cycle();
    tick(10);
    chk(st_laser_ready, 1'b0);
    tick(4);
    results();
  end
endmodule // tb
